// *** design/ilcc_pkg.sv ***
package ilcc_pkg;

  // ****************************************************************
  // Constants
  // ****************************************************************
  localparam int unsigned CLK_PERIOD_NS   = 10;
  localparam int unsigned REG_SETTLE_NS   = 3000;  // Regulator ready time
  localparam int unsigned REG_SETTLE_CYC  = (REG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RDY_FALL_OSC    = 6;     // Osc cycles to ready low
  localparam int unsigned STICK_RANGE_MIN = 7;     // Range code of 24 MHz
  localparam int unsigned TRIM_SPAN       = 16;
  // Factory code sits 32 codes clear of any multiple of 64, so no clamped user offset crosses one
  localparam logic [7:0]  FACTORY_TRIM    = 8'h60;

  localparam logic [1:0] ADDR_CTRL   = 2'h0;
  localparam logic [1:0] ADDR_TRIM   = 2'h1;
  localparam logic [1:0] ADDR_STATUS = 2'h2;
  localparam logic [1:0] ADDR_ID     = 2'h3;
  localparam logic [15:0] ID_VALUE   = 16'h00a5;   // Arbitrary value

  // Control bit positions
  localparam int unsigned C_MSI_ON   = 0;
  localparam int unsigned C_SEL_LO   = 1;  // Two bits of source select
  localparam int unsigned C_LP_RUN   = 3;
  localparam int unsigned C_WAKE_HSI = 4;
  localparam int unsigned C_SLEEP    = 5;  // Sleep request, self-clearing
  localparam int unsigned C_RANGE_LO = 8;  // Four bits of osc range
  localparam int unsigned C_LEVEL_LO = 12; // Two bits of deep-sleep level

  typedef enum logic [1:0] {SRC_MSI, SRC_HSI, SRC_PLL} ilcc_src_type;
  typedef enum {ST_RUN, ST_REG_WAIT, ST_ENTRY, ST_SLEEP} ilcc_state_type;

  typedef struct packed {
    logic [1:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ilcc_bus_type;

  typedef struct packed {
    logic multispeed_internal_osc;
    logic internal_high_speed_osc;
    logic pll;
  } ilcc_rdy_type;

endpackage

// *** design/ilcc_top.sv ***
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
module ilcc_top (
  input  wire logic                 clk_i,
  input  wire logic                 arst_n_i,
  input  wire ilcc_pkg::ilcc_bus_type bus_i,
  input  wire ilcc_pkg::ilcc_rdy_type osc_rdy_i,      // Analog ready from osc cores
  input  wire logic                 msi_clk_tick_i,   // One pulse per osc cycle
  input  wire logic                 reg_ready_i,      // Core regulator ready
  input  wire logic                 wakeup_i,
  output logic [15:0]               rdata_o,
  output logic                      system_clock_run_o,     // Gate for system clock
  output logic [1:0]                system_clock_src_o,
  output logic [7:0]                hsi_trim_o,
  output logic                      msi_en_o,
  output logic                      deep_sleep_o
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_sync_q <= 2'h0;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic src_ready(input logic [1:0] s, input ilcc_pkg::ilcc_rdy_type r,
                                     input logic msi_flag);
    unique case (s)
      2'h0:    src_ready = msi_flag;
      2'h1:    src_ready = r.internal_high_speed_osc;
      2'h2:    src_ready = r.pll;
      default: src_ready = 1'b0;
    endcase
  endfunction

  // Clamp user trim offset to +-16 steps around factory trim
  function automatic logic [7:0] trim_clamp(input logic [5:0] off);
    logic signed [6:0] v;
    v = $signed({off[5], off});
    if (v > $signed(7'(ilcc_pkg::TRIM_SPAN))) v = 7'(ilcc_pkg::TRIM_SPAN);
    if (v < -$signed(7'(ilcc_pkg::TRIM_SPAN))) v = -7'(ilcc_pkg::TRIM_SPAN);
    trim_clamp = ilcc_pkg::FACTORY_TRIM + 8'({v[6], v});
  endfunction

  // ****************************************************************
  // Registers
  // ****************************************************************
  logic [15:0] ctrl_q, ctrl_d;
  logic [5:0]  trim_q, trim_d;
  logic [15:0] rdata_q, rdata_d;
  logic        msi_flag_q, msi_flag_d;
  logic [2:0]  fall_cnt_q, fall_cnt_d;
  logic        stuck_q, stuck_d;
  logic [1:0]  src_q, src_d;
  logic        lp_q, lp_d;
  logic [11:0] settle_q, settle_d;
  logic        run_q, run_d;
  logic        sleep_q, sleep_d;
  logic        wake_hsi_q, wake_hsi_d;
  ilcc_pkg::ilcc_state_type st_q, st_d;
  logic [15:0] status;

  assign status = {9'h0, stuck_q, st_q == ilcc_pkg::ST_SLEEP, lp_q,
                   osc_rdy_i.pll, osc_rdy_i.internal_high_speed_osc, msi_flag_q, run_q};

  // Bus decode and software bits
  always_comb begin
    ctrl_d  = ctrl_q;
    trim_d  = trim_q;
    rdata_d = 16'h0;
    ctrl_d[ilcc_pkg::C_SLEEP] = 1'b0;
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        ilcc_pkg::ADDR_CTRL: ctrl_d = bus_i.wdata;
        ilcc_pkg::ADDR_TRIM: trim_d = bus_i.wdata[5:0];
        default: ;
      endcase
    end
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        ilcc_pkg::ADDR_CTRL:   rdata_d = ctrl_q;
        ilcc_pkg::ADDR_TRIM:   rdata_d = {10'h0, trim_q};
        ilcc_pkg::ADDR_STATUS: rdata_d = status;
        ilcc_pkg::ADDR_ID:     rdata_d = ilcc_pkg::ID_VALUE;
      endcase
    end
  end

  // Multispeed osc ready flag with its sticky corner
  always_comb begin
    msi_flag_d = msi_flag_q;
    fall_cnt_d = fall_cnt_q;
    stuck_d    = stuck_q;
    if (ctrl_q[ilcc_pkg::C_MSI_ON]) begin
      fall_cnt_d = 3'h0;
      stuck_d    = 1'b0;
      msi_flag_d = osc_rdy_i.multispeed_internal_osc;
    end else if (msi_flag_q && !stuck_q) begin
      if (msi_clk_tick_i) begin
        fall_cnt_d = fall_cnt_q + 3'h1;
      end
      if (fall_cnt_q == 3'(ilcc_pkg::RDY_FALL_OSC - 1) && msi_clk_tick_i) begin
        // Stopped at a high range the flag stays set
        if (ctrl_q[ilcc_pkg::C_RANGE_LO +: 4] >= 4'(ilcc_pkg::STICK_RANGE_MIN)) begin
          stuck_d = 1'b1;
        end else begin
          msi_flag_d = 1'b0;
        end
      end
    end
  end

  // Clock switching and low-power sequencing
  always_comb begin
    st_d       = st_q;
    src_d      = src_q;
    lp_d       = lp_q;
    settle_d   = settle_q;
    run_d      = 1'b1;
    sleep_d    = 1'b0;
    wake_hsi_d = wake_hsi_q;
    unique case (st_q)
      ilcc_pkg::ST_RUN: begin
        // Keep old source until the new one is ready
        if (ctrl_q[ilcc_pkg::C_SEL_LO +: 2] != src_q &&
            src_ready(ctrl_q[ilcc_pkg::C_SEL_LO +: 2], osc_rdy_i, msi_flag_q)) begin
          src_d = ctrl_q[ilcc_pkg::C_SEL_LO +: 2];
        end
        if (ctrl_q[ilcc_pkg::C_LP_RUN] != lp_q) begin
          st_d     = ilcc_pkg::ST_REG_WAIT;
          settle_d = 12'h0;
          run_d    = 1'b0;
        end else if (ctrl_q[ilcc_pkg::C_SLEEP]) begin
          st_d       = ilcc_pkg::ST_ENTRY;
          wake_hsi_d = ctrl_q[ilcc_pkg::C_WAKE_HSI];
        end
      end
      ilcc_pkg::ST_REG_WAIT: begin
        // Clock held stopped until regulator reports ready and the settle time has passed
        run_d    = 1'b0;
        settle_d = settle_q + 12'h1;
        if (reg_ready_i && settle_q >= 12'(ilcc_pkg::REG_SETTLE_CYC - 1)) begin
          lp_d  = ctrl_q[ilcc_pkg::C_LP_RUN];
          st_d  = ilcc_pkg::ST_RUN;
          run_d = 1'b1;
        end
      end
      ilcc_pkg::ST_ENTRY: begin
        // Early wakeup aborts entry, source stays as is
        if (wakeup_i) begin
          st_d = ilcc_pkg::ST_RUN;
        end else if (!(stuck_q && !ctrl_q[ilcc_pkg::C_MSI_ON])) begin
          st_d    = ilcc_pkg::ST_SLEEP;
          sleep_d = 1'b1;
        end
      end
      ilcc_pkg::ST_SLEEP: begin
        sleep_d = 1'b1;
        run_d   = 1'b0;
        if (wakeup_i) begin
          // Any level accepts the osc in any range as wakeup clock
          src_d   = wake_hsi_q ? 2'(ilcc_pkg::SRC_HSI) : 2'(ilcc_pkg::SRC_MSI);
          st_d    = ilcc_pkg::ST_RUN;
          sleep_d = 1'b0;
          run_d   = 1'b1;
        end
      end
    endcase
  end

  // State registers
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q     <= 16'h0001;
      trim_q     <= 6'h0;
      rdata_q    <= 16'h0;
      msi_flag_q <= 1'b0;
      fall_cnt_q <= 3'h0;
      stuck_q    <= 1'b0;
      src_q      <= 2'h0;
      lp_q       <= 1'b0;
      settle_q   <= 12'h0;
      run_q      <= 1'b1;
      sleep_q    <= 1'b0;
      wake_hsi_q <= 1'b0;
      st_q       <= ilcc_pkg::ST_RUN;
    end else begin
      ctrl_q     <= ctrl_d;
      trim_q     <= trim_d;
      rdata_q    <= rdata_d;
      msi_flag_q <= msi_flag_d;
      fall_cnt_q <= fall_cnt_d;
      stuck_q    <= stuck_d;
      src_q      <= src_d;
      lp_q       <= lp_d;
      settle_q   <= settle_d;
      run_q      <= run_d;
      sleep_q    <= sleep_d;
      wake_hsi_q <= wake_hsi_d;
      st_q       <= st_d;
    end
  end

  // Outputs
  logic [7:0] trim_out_q;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      trim_out_q <= ilcc_pkg::FACTORY_TRIM;
    end else begin
      trim_out_q <= trim_clamp(trim_q);
    end
  end
  assign rdata_o      = rdata_q;
  assign system_clock_run_o = run_q;
  assign system_clock_src_o = src_q;
  assign hsi_trim_o   = trim_out_q;
  assign msi_en_o     = ctrl_q[ilcc_pkg::C_MSI_ON];
  assign deep_sleep_o = sleep_q;

  // ****************************************************************
  // Checks
  // ****************************************************************
  stop_on_switch_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (st_q == ilcc_pkg::ST_RUN && ctrl_q[ilcc_pkg::C_LP_RUN] != lp_q) |=> !run_q)
    else $error("clock ran during regulator switch");
  no_sleep_stuck_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (stuck_q && !ctrl_q[ilcc_pkg::C_MSI_ON] && st_q == ilcc_pkg::ST_ENTRY) |=> !sleep_q)
    else $error("deep sleep entered with stuck ready flag");
  trim_span_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (trim_out_q <= ilcc_pkg::FACTORY_TRIM + 8'(ilcc_pkg::TRIM_SPAN)) &&
    (trim_out_q >= ilcc_pkg::FACTORY_TRIM - 8'(ilcc_pkg::TRIM_SPAN)))
    else $error("trim outside span");
  src_ready_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (st_q == ilcc_pkg::ST_RUN && $changed(src_q) && $past(st_q) == ilcc_pkg::ST_RUN)
    |-> $past(src_ready(ctrl_q[ilcc_pkg::C_SEL_LO +: 2], osc_rdy_i, msi_flag_q)))
    else $error("switched to unready source");
  abort_keeps_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (st_q == ilcc_pkg::ST_ENTRY && wakeup_i) |=> $stable(src_q) && !sleep_q)
    else $error("aborted entry changed source");
  wake_src_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (st_q == ilcc_pkg::ST_SLEEP && wakeup_i && !wake_hsi_q) |=> src_q == 2'h0)
    else $error("wakeup not on multispeed osc");

endmodule

// *** sim/test_internal_osc_lowpower_clock_ctrl.sv ***
`timescale 1ns/1ps
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
  $display("FAIL t=%0t got %h exp %h", $time, (got), (exp)); end end

module test_internal_osc_lowpower_clock_ctrl;
  logic                   clk_i;
  logic                   arst_n_i;
  ilcc_pkg::ilcc_bus_type bus_i;
  ilcc_pkg::ilcc_rdy_type osc_rdy_i;
  logic                   msi_clk_tick_i;
  logic                   reg_ready_i;
  logic                   wakeup_i;
  logic [15:0]            rdata_o;
  logic                   system_clock_run_o;
  logic [1:0]             system_clock_src_o;
  logic [7:0]             hsi_trim_o;
  logic                   msi_en_o;
  logic                   deep_sleep_o;
  logic                   tick_steady;
  logic [15:0]            rv;
  logic [5:0]             off;
  int                     error_cnt;
  int                     compares;
  int                     cycles;
  int                     seed;
  logic [5:0]             corners [9] = '{6'h00, 6'h0f, 6'h10, 6'h11, 6'h2f, 6'h30,
                                          6'h3f, 6'h20, 6'h1f};

  ilcc_top DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .bus_i(bus_i), .osc_rdy_i(osc_rdy_i),
    .msi_clk_tick_i(msi_clk_tick_i), .reg_ready_i(reg_ready_i), .wakeup_i(wakeup_i),
    .rdata_o(rdata_o), .system_clock_run_o(system_clock_run_o), .system_clock_src_o(system_clock_src_o),
    .hsi_trim_o(hsi_trim_o), .msi_en_o(msi_en_o), .deep_sleep_o(deep_sleep_o));

  // ****************************************************************
  // Clock, oscillator core model and timeout
  // ****************************************************************
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Multispeed osc ready follows enable; ticks steady or random
  always @(posedge clk_i) begin
    osc_rdy_i.multispeed_internal_osc <= msi_en_o;
    msi_clk_tick_i <= tick_steady ? ~msi_clk_tick_i : 1'($random(seed));
    cycles++;
    if (cycles == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // ****************************************************************
  // Bus tasks and expectation functions
  // ****************************************************************
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk_i);
    bus_i.addr <= a;
    bus_i.wdata <= d;
    bus_i.wr <= 1'b1;
    @(posedge clk_i);
    bus_i.wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [1:0] a, output logic [15:0] d);
    @(posedge clk_i);
    bus_i.addr <= a;
    bus_i.rd <= 1'b1;
    @(posedge clk_i);
    bus_i.rd <= 1'b0;
    #1 d = rdata_o;
  endtask

  function automatic logic [15:0] ctl(input logic on, input logic [1:0] src, input logic lp,
                                      input logic wk, input logic slp, input logic [3:0] rng,
                                      input logic [1:0] lvl);
    return {2'h0, lvl, rng, 2'h0, slp, wk, lp, src, on};
  endfunction

  // Offset clamped to the user trim span around factory trim
  function automatic logic [7:0] trim_exp(input logic [5:0] o);
    int s;
    s = $signed(o);
    if (s > int'(ilcc_pkg::TRIM_SPAN)) s = ilcc_pkg::TRIM_SPAN;
    if (s < -int'(ilcc_pkg::TRIM_SPAN)) s = -int'(ilcc_pkg::TRIM_SPAN);
    return 8'(int'(ilcc_pkg::FACTORY_TRIM) + s);
  endfunction

  task automatic wrap_up();
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    seed = 32'h9bd9;
    {error_cnt, compares, cycles} = '0;
    arst_n_i = 1'b0;
    bus_i = '0;
    osc_rdy_i = '{multispeed_internal_osc: 1'b1, internal_high_speed_osc: 1'b0, pll: 1'b0};
    {msi_clk_tick_i, tick_steady, wakeup_i} = '0;
    reg_ready_i = 1'b1;
    repeat (4) @(posedge clk_i);
    arst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK({system_clock_run_o, system_clock_src_o, hsi_trim_o, msi_en_o}, {1'b1, 2'h0, ilcc_pkg::FACTORY_TRIM, 1'b1})
    rd(ilcc_pkg::ADDR_ID, rv);
    `CHK(rv, ilcc_pkg::ID_VALUE)
    $display("test reset done");
    // Trim corners then random offsets
    for (int i = 0; i < 17; i++) begin
      off = (i < 9) ? corners[i] : 6'($random(seed));
      wr(ilcc_pkg::ADDR_TRIM, {10'h0, off});
      repeat (2) @(posedge clk_i);
      `CHK(hsi_trim_o, trim_exp(off))
    end
    rd(ilcc_pkg::ADDR_TRIM, rv);
    `CHK(rv, {10'h0, off})
    $display("test trim done");
    // New source taken only once its ready is up
    for (int s = 1; s < 3; s++) begin
      wr(ilcc_pkg::ADDR_CTRL, ctl(1'b1, 2'(s), 1'b0, 1'b0, 1'b0, 4'h0, 2'h0));
      repeat (10) @(posedge clk_i);
      `CHK(system_clock_src_o, 2'(s - 1))
      if (s == 1) osc_rdy_i.internal_high_speed_osc <= 1'b1;
      else osc_rdy_i.pll <= 1'b1;
      for (int i = 0; i < 20 && system_clock_src_o !== 2'(s); i++) @(posedge clk_i);
      `CHK(system_clock_src_o, 2'(s))
    end
    $display("test source switch done");
    // Low-power run entry and exit stop the clock until regulator ready
    for (int lp = 1; lp >= 0; lp--) begin
      reg_ready_i <= 1'b0;
      wr(ilcc_pkg::ADDR_CTRL, ctl(1'b1, 2'h0, 1'(lp), 1'b0, 1'b0, 4'h0, 2'h0));
      repeat (400) @(posedge clk_i);
      `CHK(system_clock_run_o, 1'b0)
      reg_ready_i <= 1'b1;
      for (int i = 0; i < 50 && system_clock_run_o !== 1'b1; i++) @(posedge clk_i);
      `CHK(system_clock_run_o, 1'b1)
    end
    $display("test low-power run done");
    // Deep sleep at levels 1 and 2, wake on either source
    for (int k = 0; k < 4; k++) begin
      // System clock equals the wakeup clock, so the high range needs no lowering
      wr(ilcc_pkg::ADDR_CTRL, ctl(1'b1, 2'(k % 2), 1'b0, 1'(k), 1'b1, 4'hb, 2'(1 + k / 2)));
      // Levels 1 and 2 only, never deep-sleep 0 at a high range
      // No range raise follows a deep-sleep 0 exit
      // Sleep is never requested on the multispeed osc with another wakeup clock
      for (int i = 0; i < 20 && deep_sleep_o !== 1'b1; i++) @(posedge clk_i);
      `CHK(deep_sleep_o, 1'b1)
      wakeup_i <= 1'b1;
      for (int i = 0; i < 20 && deep_sleep_o !== 1'b0; i++) @(posedge clk_i);
      wakeup_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      `CHK(system_clock_src_o, 2'(k % 2))
    end
    // Early wakeup aborts entry and keeps the high-speed source
    wr(ilcc_pkg::ADDR_CTRL, ctl(1'b1, 2'h1, 1'b0, 1'b0, 1'b0, 4'h0, 2'h0));
    repeat (5) @(posedge clk_i);
    wakeup_i <= 1'b1;
    wr(ilcc_pkg::ADDR_CTRL, ctl(1'b1, 2'h1, 1'b0, 1'b0, 1'b1, 4'h0, 2'h0));
    rv = '0;
    for (int i = 0; i < 10; i++) begin
      @(posedge clk_i);
      rv[0] = rv[0] | deep_sleep_o;
    end
    wakeup_i <= 1'b0;
    `CHK({rv[0], system_clock_src_o}, {1'b0, 2'h1})
    $display("test deep sleep done");
    // Ready flag falls within six osc cycles at a low range
    tick_steady <= 1'b1;
    wr(ilcc_pkg::ADDR_CTRL, ctl(1'b0, 2'h1, 1'b0, 1'b0, 1'b0, 4'h3, 2'h0));
    // On the high-speed osc, osc stopped, flag awaited low before any sleep
    repeat (13) @(posedge clk_i);
    rd(ilcc_pkg::ADDR_STATUS, rv);
    `CHK({rv[6], rv[1]}, 2'b00)
    // Stopped at the 24 MHz range the flag sticks and blocks entry
    wr(ilcc_pkg::ADDR_CTRL, ctl(1'b1, 2'h1, 1'b0, 1'b0, 1'b0, 4'h7, 2'h0));
    repeat (10) @(posedge clk_i);
    wr(ilcc_pkg::ADDR_CTRL, ctl(1'b0, 2'h1, 1'b0, 1'b0, 1'b0, 4'h7, 2'h0));
    repeat (20) @(posedge clk_i);
    rd(ilcc_pkg::ADDR_STATUS, rv);
    `CHK({rv[6], rv[1]}, 2'b11)
    wr(ilcc_pkg::ADDR_CTRL, ctl(1'b0, 2'h1, 1'b0, 1'b0, 1'b1, 4'h7, 2'h1));
    repeat (20) @(posedge clk_i);
    `CHK(deep_sleep_o, 1'b0)
    wr(ilcc_pkg::ADDR_CTRL, ctl(1'b1, 2'h1, 1'b0, 1'b0, 1'b0, 4'h7, 2'h0));
    repeat (4) @(posedge clk_i);
    rd(ilcc_pkg::ADDR_STATUS, rv);
    `CHK(rv[6], 1'b0)
    $display("test ready flag done");
    wrap_up();
  end
endmodule
